// ===== gate_driver_status_register_map.sv
/*
 Register bank of a three-phase gate driver reached over a 16-bit serial slave frame:
 two read-only status words and five read/write control words at addresses 0 to 6.
 Assumes fault sources arrive as synchronous levels and that sleep and undervoltage
 events are given as levels that hold the bank at defaults.
*/
// What this block does
// - Every reserved bit resets to zero.
// - Status registers report warnings and faults and are read-only over the serial port.
// - The primary status word sits at address 0, is read-only and resets to all zeros.
// - Bit 10 of the primary status word is the OR of all error bits and matches the error pin.
// - Bit 9 flags drain-source monitor overcurrent.
// - Bit 8 flags a gate drive error.
// - Bit 7 flags undervoltage lockout.
// - Bit 6 flags overtemperature shutdown.
// - Bits 5 to 0 flag per-transistor overcurrent: A high, A low, B high, B low, C high, C low.
// - The secondary status word sits at address 1 and is read-only.
// - Each frame shifts out five pad bits then the addressed register's current 11 bits.
// - All registers return to defaults at power up, on sleep entry and on undervoltage.
`timescale 1ns/100ps
`include "gate_regs_params.svh"
module gate_driver_status_register_map
  import gate_regs_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic                     sleep_entry,
  input  wire logic                     undervoltage_lockout_flag_event,
  input  wire logic                     cs_n,
  input  wire logic                     sclk,
  input  wire logic                     sdi,
  output logic                          sdo,
  output logic                          sdo_oe,
  input  wire logic                     drain_source_overcurrent_flag,
  input  wire logic                     gate_drive_error_flag,
  input  wire logic                     undervoltage_lockout_flag,
  input  wire logic                     overtemp_shutdown_flag,
  input  wire logic [5:0]               phase_overcurrent,
  input  wire gate_regs_pkg::reg_word_t secondary_status_in,
  output logic                          error_indicator_pin_n,
  output logic                          error_indicator_pin_oe,
  output gate_regs_pkg::reg_word_t      driver_control_q,
  output gate_regs_pkg::reg_word_t      high_side_gate_strength_q,
  output gate_regs_pkg::reg_word_t      low_side_gate_strength_q,
  output gate_regs_pkg::reg_word_t      overcurrent_protection_control_q,
  output gate_regs_pkg::reg_word_t      current_sense_amp_control_q,
  output logic                          fault_clear_pulse
);
  import gate_regs_pkg::*;

  reg_word_t              error_status_primary_q;
  reg_word_t              error_status_secondary_q;
  reg_word_t              tx_word;
  reg_word_t              wr_data;
  reg_addr_t              start_addr;
  reg_addr_t              wr_addr;
  logic                   start_pulse;
  logic                   frame_valid;
  logic [`FRAME_BITS-1:0] frame_data;
  logic                   defaults;
  logic                   wr_en;
  logic                   locked;
  logic [2:0]             lock_wr;
  logic                   any_error;
  logic [5:0]             phase_oc_d;
  logic                   ds_oc_d;

  // Reply lookup by register address; unmapped and reserved slots read as zero
  function automatic reg_word_t read_mux(input reg_addr_t a);
    unique case (a)
      `ADDR_ERR_PRIMARY:   read_mux = error_status_primary_q;
      `ADDR_ERR_SECONDARY: read_mux = error_status_secondary_q;
      `ADDR_DRIVER_CTRL:   read_mux = driver_control_q;
      `ADDR_HS_GATE:       read_mux = high_side_gate_strength_q;
      `ADDR_LS_GATE:       read_mux = low_side_gate_strength_q;
      `ADDR_OCP_CTRL:      read_mux = overcurrent_protection_control_q;
      `ADDR_CSA_CTRL:      read_mux = current_sense_amp_control_q;
      default:             read_mux = `RST_STATUS;
    endcase
  endfunction : read_mux

  serial_frame u_frame (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .cs_n        (cs_n),
    .sclk        (sclk),
    .sdi         (sdi),
    .tx_word     (tx_word),
    .sdo         (sdo),
    .sdo_oe      (sdo_oe),
    .start_pulse (start_pulse),
    .frame_valid (frame_valid),
    .frame_data  (frame_data)
  );

  // Address lies in the frame head, so the reply word is latched at the 5th falling edge;
  // the last address bit is still on the data pin at that edge and is taken live
  logic       head_sclk_q;
  logic [2:0] head_cnt_q;
  reg_addr_t  head_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      head_sclk_q <= 1'b0;
      head_cnt_q  <= 3'h0;
      head_q      <= '0;
    end else begin
      head_sclk_q <= sclk;
      if (start_pulse) begin
        head_cnt_q <= 3'h0;
      end else if (!cs_n && head_sclk_q && !sclk && head_cnt_q != 3'h5) begin
        head_cnt_q <= head_cnt_q + 3'h1;
        head_q     <= {head_q[2:0], sdi};
      end
    end
  end
  assign start_addr = {head_q[2:0], sdi};
  assign tx_word    = read_mux(start_addr);

  assign defaults   = !resetn || sleep_entry || undervoltage_lockout_flag_event;
  assign wr_en      = frame_valid && !frame_data[`FRAME_BITS-1];
  assign wr_addr    = frame_data[`FRAME_BITS-2 -: `ADDR_WIDTH];
  assign wr_data    = frame_data[`REG_WIDTH-1:0];
  assign lock_wr    = wr_data[`LOCK_LSB +: 3];
  assign locked     = high_side_gate_strength_q[`LOCK_LSB +: 3] == `LOCK_CODE_LOCK;

  assign ds_oc_d    = drain_source_overcurrent_flag | (|phase_overcurrent);
  assign phase_oc_d = phase_overcurrent;
  assign any_error  = ds_oc_d | gate_drive_error_flag | undervoltage_lockout_flag
                    | overtemp_shutdown_flag | (|secondary_status_in);

  // Status follows live conditions; no write path exists for it
  always_ff @(posedge sys_clk) begin
    if (defaults) begin
      error_status_primary_q   <= `RST_STATUS;
      error_status_secondary_q <= `RST_STATUS;
    end else begin
      error_status_primary_q[`BIT_SUMMARY]  <= any_error;
      error_status_primary_q[`BIT_DS_OCP]   <= ds_oc_d;
      error_status_primary_q[`BIT_GATE_ERR] <= gate_drive_error_flag;
      error_status_primary_q[`BIT_UNDERVOLTAGE_LOCKOUT_FLAG]     <= undervoltage_lockout_flag;
      error_status_primary_q[`BIT_OVERTEMP_SHUTDOWN_FLAG]     <= overtemp_shutdown_flag;
      error_status_primary_q[5:0]           <= phase_oc_d;
      error_status_secondary_q              <= secondary_status_in;
    end
  end

  // Pin and summary bit come from the same term on the same edge
  always_ff @(posedge sys_clk) begin
    if (defaults) begin
      error_indicator_pin_n  <= 1'b0;
      error_indicator_pin_oe <= 1'b0;
    end else begin
      error_indicator_pin_n  <= 1'b0;
      error_indicator_pin_oe <= any_error;
    end
  end

  // Status addresses are not decoded for writes at all
  always_ff @(posedge sys_clk) begin
    if (defaults) begin
      driver_control_q                 <= `RST_DRIVER_CTRL;
      high_side_gate_strength_q        <= `RST_HS_GATE;
      low_side_gate_strength_q         <= `RST_LS_GATE;
      overcurrent_protection_control_q <= `RST_OCP_CTRL;
      current_sense_amp_control_q      <= `RST_CSA_CTRL;
      fault_clear_pulse                <= 1'b0;
    end else begin
      fault_clear_pulse                <= 1'b0;
      driver_control_q[`CLR_BIT]       <= 1'b0;
      if (wr_en) begin
        unique case (wr_addr)
          `ADDR_DRIVER_CTRL: begin
            if (locked)
              driver_control_q <= (driver_control_q & ~`DRV_LOCKFREE_MASK)
                                | (wr_data & `DRV_LOCKFREE_MASK & ~11'h001);
            else
              driver_control_q <= wr_data & `DRV_RSVD_MASK & ~11'h001;
            fault_clear_pulse <= wr_data[`CLR_BIT];
          end
          `ADDR_HS_GATE: begin
            if (!locked) begin
              high_side_gate_strength_q[`LOCK_LSB-1:0] <= wr_data[`LOCK_LSB-1:0];
              if (lock_wr == `LOCK_CODE_LOCK)
                high_side_gate_strength_q[`LOCK_LSB +: 3] <= lock_wr;
            end else if (lock_wr == `LOCK_CODE_UNLOCK) begin
              high_side_gate_strength_q[`LOCK_LSB +: 3] <= lock_wr;
            end
          end
          `ADDR_LS_GATE:  if (!locked) low_side_gate_strength_q <= wr_data;
          `ADDR_OCP_CTRL: if (!locked) overcurrent_protection_control_q <= wr_data;
          `ADDR_CSA_CTRL: if (!locked) current_sense_amp_control_q <= wr_data;
          default: ;
        endcase
      end
    end
  end
endmodule : gate_driver_status_register_map

// ===== gate_driver_status_register_map_tb.sv
/*
 Testbench for the gate driver register bank: frames from the master model, checks at ports.
 Assumes the reply word carries the register addressed in the same frame.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module gate_driver_status_register_map_tb;
  import gate_regs_pkg::*;
  logic      sys_clk = 1'b0;
  logic      resetn = 1'b0;
  logic      sleep_entry, undervoltage_lockout_flag_event, cs_n, sclk, sdi, sdo, sdo_oe, fault_clear_pulse;
  logic      drain_source_overcurrent_flag, gate_drive_error_flag, undervoltage_lockout_flag;
  logic      overtemp_shutdown_flag, error_indicator_pin_n, error_indicator_pin_oe;
  logic [5:0] phase_overcurrent;
  reg_word_t secondary_status_in, driver_control_q, high_side_gate_strength_q;
  reg_word_t low_side_gate_strength_q, overcurrent_protection_control_q, current_sense_amp_control_q;
  logic [15:0] rx;
  logic [9:0]  ev;
  int        err_count, comparisons, cycles, pulses;
  gate_driver_status_register_map dut (.*);
  spi_master_model m (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (fault_clear_pulse === 1'b1) pulses++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end
  task close_out;
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task wr(input reg_addr_t a, input reg_word_t d);
    m.xfer({1'b0, a, d}, rx);
  endtask : wr
  task rd(input reg_addr_t a, input reg_word_t exp);
    m.xfer({1'b1, a, 11'h000}, rx);
    `CHK(rx, {5'h00, exp})
  endtask : rd
  task rd_chk(input reg_word_t exp);
    rd(4'h0, exp);
  endtask : rd_chk
  task ctl(input reg_word_t d, h, l, o, c);
    `CHK({driver_control_q, high_side_gate_strength_q, low_side_gate_strength_q,
          overcurrent_protection_control_q, current_sense_amp_control_q}, {d, h, l, o, c})
  endtask : ctl
  initial begin
    {sleep_entry, undervoltage_lockout_flag_event, drain_source_overcurrent_flag, gate_drive_error_flag} = 4'h0;
    {undervoltage_lockout_flag, overtemp_shutdown_flag, phase_overcurrent} = 8'h00;
    secondary_status_in = 11'h000;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ctl(11'h000, 11'h3FF, 11'h000, 11'h000, 11'h000);
    rd_chk(11'h000);
    for (int i = 0; i < 10; i++) begin
      ev = 10'h001 << i;
      {drain_source_overcurrent_flag, gate_drive_error_flag, undervoltage_lockout_flag,
       overtemp_shutdown_flag, phase_overcurrent} <= ev;
      // A per-transistor trip is a drain-source monitor trip, so bit 9 rises with it
      rd_chk({1'b1, ev[9] | (|ev[5:0]), ev[8:0]});
      `CHK(error_indicator_pin_oe, 1'b1)
    end
    {drain_source_overcurrent_flag, gate_drive_error_flag, undervoltage_lockout_flag,
     overtemp_shutdown_flag, phase_overcurrent} <= 10'h000;
    secondary_status_in <= 11'h400;
    rd_chk(11'h400);
    rd(4'h1, 11'h400);
    secondary_status_in <= 11'h000;
    rd_chk(11'h000);
    `CHK(error_indicator_pin_oe, 1'b0)
    // Reserved bit 10 and the self-clearing bit 0 are both set on purpose
    wr(4'h2, 11'h7F7);
    wr(4'h3, 11'h3A5);
    wr(4'h4, 11'h5A5);
    wr(4'h5, 11'h2DB);
    wr(4'h6, 11'h1C3);
    ctl(11'h3F6, 11'h3A5, 11'h5A5, 11'h2DB, 11'h1C3);
    `CHK(pulses, 1)
    rd(4'h2, 11'h3F6);
    rd(4'h6, 11'h1C3);
    rd(4'h7, 11'h000);
    wr(4'h0, 11'h7FF);
    wr(4'h1, 11'h7FF);
    rd_chk(11'h000);
    rd(4'h1, 11'h000);
    ctl(11'h3F6, 11'h3A5, 11'h5A5, 11'h2DB, 11'h1C3);
    wr(4'h3, 11'h6A5);
    `CHK(rx, {5'h00, 11'h3A5})
    wr(4'h5, 11'h000);
    wr(4'h2, 11'h005);
    ctl(11'h3F4, 11'h6A5, 11'h5A5, 11'h2DB, 11'h1C3);
    wr(4'h3, 11'h3A5);
    wr(4'h5, 11'h000);
    ctl(11'h3F4, 11'h3A5, 11'h5A5, 11'h000, 11'h1C3);
    sleep_entry <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sleep_entry <= 1'b0;
    repeat (2) @(posedge sys_clk);
    ctl(11'h000, 11'h3FF, 11'h000, 11'h000, 11'h000);
    wr(4'h4, 11'h5A5);
    undervoltage_lockout_flag_event <= 1'b1;
    repeat (3) @(posedge sys_clk);
    undervoltage_lockout_flag_event <= 1'b0;
    repeat (2) @(posedge sys_clk);
    ctl(11'h000, 11'h3FF, 11'h000, 11'h000, 11'h000);
    close_out();
  end
endmodule : gate_driver_status_register_map_tb

// ===== gate_regs_chk.sv
/*
 Port checker for the gate driver register bank.
 Assumes it is bound into every instance of the bank and sees only its ports.
*/
`timescale 1ns/100ps
`include "gate_regs_params.svh"
module gate_regs_chk
  import gate_regs_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      resetn,
  input wire logic      sleep_entry,
  input wire logic      undervoltage_lockout_flag_event,
  input wire logic      cs_n,
  input wire logic      sdo_oe,
  input wire logic      drain_source_overcurrent_flag,
  input wire logic      gate_drive_error_flag,
  input wire logic      undervoltage_lockout_flag,
  input wire logic      overtemp_shutdown_flag,
  input wire logic [5:0] phase_overcurrent,
  input wire gate_regs_pkg::reg_word_t secondary_status_in,
  input wire logic      error_indicator_pin_n,
  input wire logic      error_indicator_pin_oe,
  input wire gate_regs_pkg::reg_word_t driver_control_q,
  input wire gate_regs_pkg::reg_word_t high_side_gate_strength_q,
  input wire gate_regs_pkg::reg_word_t low_side_gate_strength_q,
  input wire gate_regs_pkg::reg_word_t overcurrent_protection_control_q,
  input wire gate_regs_pkg::reg_word_t current_sense_amp_control_q
);
  import gate_regs_pkg::*;
  logic [20:0] src;
  logic [20:0] src_q;
  logic [2:0]  stab_q;
  logic [54:0] ctl;
  logic        settled;
  assign src = {drain_source_overcurrent_flag, gate_drive_error_flag, undervoltage_lockout_flag,
                overtemp_shutdown_flag, phase_overcurrent, secondary_status_in};
  assign ctl = {driver_control_q, high_side_gate_strength_q, low_side_gate_strength_q,
                overcurrent_protection_control_q, current_sense_amp_control_q};
  // The pin lags its sources by a cycle, so a cycle in which the sources move is never judged
  assign settled = stab_q >= 3'h3 && src == src_q && !sleep_entry && !undervoltage_lockout_flag_event;
  // Counts quiet cycles so the summary is judged only after the pipeline settles
  always_ff @(posedge sys_clk) begin
    src_q <= src;
    if (!resetn || sleep_entry || undervoltage_lockout_flag_event || src != src_q) stab_q <= 3'h0;
    else if (stab_q != 3'h7) stab_q <= stab_q + 3'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_pin_data_low: assert property (error_indicator_pin_n == 1'b0)
    else $error("error pin data not low");
  a_summary_or: assert property (settled |-> error_indicator_pin_oe == (|src))
    else $error("summary differs from OR of sources");
  a_undervoltage_lockout_flag_summary: assert property (settled && undervoltage_lockout_flag |-> error_indicator_pin_oe)
    else $error("undervoltage not on summary");
  a_phase_summary: assert property (settled && (|phase_overcurrent) |-> error_indicator_pin_oe)
    else $error("phase overcurrent not on summary");
  a_defaults_held: assert property ((sleep_entry || undervoltage_lockout_flag_event)[*2] |-> ctl == {`RST_DRIVER_CTRL,
    `RST_HS_GATE, `RST_LS_GATE, `RST_OCP_CTRL, `RST_CSA_CTRL}) else $error("registers not at defaults");
  a_rsvd_bit_zero: assert property (driver_control_q[10] == 1'b0)
    else $error("reserved driver bit set");
  a_idle_quiet: assert property (cs_n[*4] |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_select_drives: assert property ((!cs_n)[*4] |-> sdo_oe)
    else $error("data out not driven while selected");
  a_ctrl_hold_idle: assert property ((cs_n && !sleep_entry && !undervoltage_lockout_flag_event)[*6] |-> $stable(ctl))
    else $error("control changed without a frame");
endmodule : gate_regs_chk
bind gate_driver_status_register_map gate_regs_chk chk (.*);

// ===== gate_regs_params.svh
/*
 Register map constants for the gate driver register bank: offsets, field positions,
 reset values and frame sizes. Assumes inclusion by bare name from design files.
*/
`ifndef GATE_REGS_PARAMS_SVH
`define GATE_REGS_PARAMS_SVH

`define REG_WIDTH            11
`define ADDR_WIDTH           4
`define FRAME_BITS           16
`define FRAME_CNT_WIDTH      5
`define PAD_BITS             5

`define ADDR_ERR_PRIMARY     4'h0
`define ADDR_ERR_SECONDARY   4'h1
`define ADDR_DRIVER_CTRL     4'h2
`define ADDR_HS_GATE         4'h3
`define ADDR_LS_GATE         4'h4
`define ADDR_OCP_CTRL        4'h5
`define ADDR_CSA_CTRL        4'h6
`define ADDR_RESERVED        4'h7

`define BIT_SUMMARY          10
`define BIT_DS_OCP           9
`define BIT_GATE_ERR         8
`define BIT_UNDERVOLTAGE_LOCKOUT_FLAG             7
`define BIT_OVERTEMP_SHUTDOWN_FLAG             6

`define RST_STATUS           11'h000
`define RST_DRIVER_CTRL      11'h000
`define RST_HS_GATE          11'h3FF
`define RST_LS_GATE          11'h000
`define RST_OCP_CTRL         11'h000
`define RST_CSA_CTRL         11'h000

`define LOCK_LSB             8
`define LOCK_CODE_LOCK       3'h6
`define LOCK_CODE_UNLOCK     3'h3
`define CLR_BIT              0
`define DRV_LOCKFREE_MASK    11'h007
`define DRV_RSVD_MASK        11'h3FF

`endif

// ===== gate_regs_pkg.sv
/*
 Types shared by the gate driver register bank.
 Assumes gate_regs_params.svh is on the include path.
*/
`include "gate_regs_params.svh"
package gate_regs_pkg;
  typedef logic [`REG_WIDTH-1:0]  reg_word_t;
  typedef logic [`ADDR_WIDTH-1:0] reg_addr_t;
  typedef enum logic [1:0] {
    FR_IDLE,
    FR_SHIFT,
    FR_DONE
  } frame_state_e;
endpackage : gate_regs_pkg

// ===== serial_frame.sv
/*
 Serial slave framer: samples chip select, serial clock and data in the system clock,
 captures on falling serial clock edges, shifts out on rising edges, and flags a complete
 16-bit frame on chip select release. Assumes all pins synchronous to sys_clk.
*/
`timescale 1ns/100ps
`include "gate_regs_params.svh"
module serial_frame
  import gate_regs_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    cs_n,
  input  wire logic                    sclk,
  input  wire logic                    sdi,
  input  wire gate_regs_pkg::reg_word_t tx_word,
  output logic                         sdo,
  output logic                         sdo_oe,
  output logic                         start_pulse,
  output logic                         frame_valid,
  output logic [`FRAME_BITS-1:0]       frame_data
);
  import gate_regs_pkg::*;

  logic                       sclk_q;
  logic                       cs_n_q;
  logic [`FRAME_CNT_WIDTH-1:0] cnt_q;
  logic [`FRAME_BITS-1:0]     shin_q;
  logic [`FRAME_BITS-1:0]     shout_q;
  logic                       overrun_q;

  always_ff @(posedge sys_clk) begin
    sclk_q <= sclk;
    cs_n_q <= cs_n;
  end

  assign start_pulse = cs_n_q & ~cs_n;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q       <= '0;
      shin_q      <= '0;
      overrun_q   <= 1'b0;
      frame_valid <= 1'b0;
      frame_data  <= '0;
    end else begin
      frame_valid <= 1'b0;
      if (start_pulse) begin
        cnt_q     <= '0;
        overrun_q <= 1'b0;
      end else if (!cs_n && sclk_q && !sclk) begin
        shin_q <= {shin_q[`FRAME_BITS-2:0], sdi};
        if (cnt_q == `FRAME_CNT_WIDTH'(`FRAME_BITS))
          overrun_q <= 1'b1;
        else
          cnt_q <= cnt_q + 1'b1;
      end else if (cs_n && !cs_n_q) begin
        // Short or long frames are dropped whole
        frame_valid <= (cnt_q == `FRAME_CNT_WIDTH'(`FRAME_BITS)) && !overrun_q;
        frame_data  <= shin_q;
      end
    end
  end

  // Pad bits go out first; the register word is loaded at the 5th capture, once the
  // address is complete, so reads and writes both return the addressed register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shout_q <= '0;
      sdo     <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      sdo_oe <= ~cs_n;
      if (start_pulse) begin
        shout_q <= '0;
        sdo     <= 1'b0;
      end else if (!cs_n && sclk_q && !sclk && cnt_q == `FRAME_CNT_WIDTH'(`PAD_BITS - 1)) begin
        shout_q <= {tx_word, {`PAD_BITS{1'b0}}};
      end else if (!cs_n && !sclk_q && sclk) begin
        sdo     <= shout_q[`FRAME_BITS-1];
        shout_q <= {shout_q[`FRAME_BITS-2:0], 1'b0};
      end
    end
  end
endmodule : serial_frame

// ===== spi_master_model.sv
/*
 Serial master model: sends whole 16-bit frames, MSB first, and collects the reply.
 Assumes the slave samples its pins in sys_clk; each clock level is held three cycles.
*/
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic sys_clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic idle_q = 1'b0;
  logic line;
  // A released line shows a toggling pattern, never a stale bit
  assign line = sdo_oe ? sdo : idle_q;
  always @(posedge sys_clk) idle_q <= ~idle_q;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  task automatic xfer(input logic [15:0] word, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int i = 15; i >= 0; i--) begin
      sdi  <= word[i];
      sclk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) rx = {rx[14:0], line};
      @(posedge sys_clk) sclk <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    cs_n <= 1'b1;
    repeat (24) @(posedge sys_clk);
  endtask : xfer
endmodule : spi_master_model
